//--- oss_pkg.sv
// Constants, types and field layout of the oscillator source select block
// Behaviour
// - Two fast sources exist: fast crystal and an 8MHz fast RC oscillator.
// - Two slow sources exist: 32.768kHz slow crystal and 32kHz slow RC.
// - Run-time bits choose fast or slow system clock: speed bit, divider field.
// - Physical fast and slow sources come from configuration, not registers.
// - Configuration must name exactly one fast and one slow source.
// - Both crystals share pins; both enabled together is never accepted.
// - Unused slow crystal releases its pins for I/O or the fast crystal.
// - With fast RC and slow RC in use, the crystal port pins act as plain I/O.
// - Slow crystal low-power bit: 0 quick-start mode, 1 low-power mode.
// - Power-on clears the low-power bit so the slow crystal quick-starts.
// - Slow crystal clocks normally whatever the low-power bit says.
// - Oscillators also clock the watchdog and the time-base logic.
// - Sleep or idle gates the processor clock; a slow clock stays for timers.
// - Slow crystal counts as available only after a start-up delay.
// - Speed bit low: divider 000/001 slow, 010 fast/64, 011 fast/32.
`default_nettype none

package oss_pkg;

  // Nominal source rates
  localparam int unsigned CLK_SYS_HZ = 100_000_000;
  localparam int unsigned FAST_RC_HZ = 8_000_000;
  localparam int unsigned SLOW_XTAL_HZ = 32_768;
  localparam int unsigned SLOW_RC_HZ = 32_000;
  localparam int unsigned LP_ADVICE_S = 2;

  // Register index map
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam logic [3:0] ADDR_MODE = 4'h0;
  localparam logic [3:0] ADDR_TBC = 4'h1;
  localparam logic [3:0] ADDR_CFG = 4'h2;

  // Mode register fields
  localparam int unsigned MODE_SPEED_BIT = 0;
  localparam int unsigned MODE_IDLE_BIT = 1;
  localparam int unsigned MODE_FRDY_BIT = 2;
  localparam int unsigned MODE_SRDY_BIT = 3;
  localparam int unsigned MODE_FWAKE_BIT = 4;
  localparam int unsigned MODE_DIV_LSB = 5;
  localparam logic [7:0] MODE_RST = 8'h03;
  localparam logic [7:0] MODE_WMASK = 8'hf3;

  // Time-base control and configuration status fields
  localparam int unsigned TBC_LP_BIT = 0;
  localparam logic TBC_LP_RST = 1'h0;
  localparam int unsigned CFG_SYSON_BIT = 0;
  localparam int unsigned CFG_FXTAL_BIT = 1;
  localparam int unsigned CFG_SXTAL_BIT = 2;
  localparam int unsigned CFG_ERR_BIT = 3;
  localparam int unsigned CFG_DONE_BIT = 4;

  // Configuration option codes
  localparam logic [1:0] CFG_SRC_XTAL = 2'h1;
  localparam logic [1:0] CFG_SRC_RC = 2'h2;

  // Start-up counts in source edges; strap wait in system clock cycles
  localparam int unsigned SLOW_START_EDGES = 1024;
  localparam int unsigned FAST_START_EDGES = 128;
  localparam logic [1:0] STRAP_WAIT = 2'h3;

  // Synchroniser bit positions
  localparam int unsigned SYN_FX = 0;
  localparam int unsigned SYN_FR = 1;
  localparam int unsigned SYN_SX = 2;
  localparam int unsigned SYN_SR = 3;
  localparam int unsigned SYN_CFG = 4;
  localparam int unsigned SYN_W = 8;

  // System clock selections, slowest source first
  typedef enum logic [2:0] {
    SEL_SLOW,
    SEL_DIV64,
    SEL_DIV32,
    SEL_DIV16,
    SEL_DIV8,
    SEL_DIV4,
    SEL_DIV2,
    SEL_FAST
  } oss_sel_e;

  typedef enum logic [1:0] {
    SW_IDLE,
    SW_RUN,
    SW_PARK,
    SW_ARM
  } oss_sw_e;

  // Shared crystal pin pair function
  typedef struct packed {
    logic gpio;
    logic fast_xtal;
    logic slow_xtal;
  } oss_pins_s;

endpackage : oss_pkg

`default_nettype wire

//--- oss_clk_switch.sv
// Glitch-free selector between sampled clock levels
`default_nettype none

module oss_clk_switch
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Candidate levels and request
  input wire logic [7:0] cand_i,
  input wire oss_pkg::oss_sel_e req_sel_i,
  input wire logic req_ok_i,
  // Switched clock
  output logic clk_o,
  output oss_pkg::oss_sel_e cur_sel_o
);

  oss_pkg::oss_sw_e state_reg;
  oss_pkg::oss_sw_e state_next;
  oss_pkg::oss_sel_e cur_reg;
  oss_pkg::oss_sel_e cur_next;
  logic clk_reg;
  logic clk_next;
  wire logic cur_lvl;
  wire logic change;

  assign cur_lvl = cand_i[cur_reg];
  assign change = req_ok_i && (req_sel_i != cur_reg);

  // Old clock parked low, then new one joined on its low phase
  always_comb
  begin
    state_next = state_reg;
    cur_next = cur_reg;
    clk_next = clk_reg;
    case (state_reg)
      oss_pkg::SW_IDLE:
      begin
        clk_next = 1'b0;
        if (req_ok_i)
        begin
          cur_next = req_sel_i;
          state_next = oss_pkg::SW_ARM;
        end
      end
      oss_pkg::SW_RUN:
      begin
        clk_next = cur_lvl;
        if (change)
        begin
          state_next = oss_pkg::SW_PARK;
        end
      end
      oss_pkg::SW_PARK:
      begin
        clk_next = clk_reg & cur_lvl;
        if (!cur_lvl)
        begin
          cur_next = req_sel_i;
          state_next = oss_pkg::SW_ARM;
        end
      end
      oss_pkg::SW_ARM:
      begin
        clk_next = 1'b0;
        if (!cur_lvl)
        begin
          state_next = oss_pkg::SW_RUN;
        end
      end
      default:
      begin
        state_next = oss_pkg::SW_IDLE;
        clk_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      state_reg <= oss_pkg::SW_IDLE;
      cur_reg <= oss_pkg::SEL_SLOW;
      clk_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cur_reg <= cur_next;
      clk_reg <= clk_next;
    end
  end

  assign clk_o = clk_reg;
  assign cur_sel_o = cur_reg;

endmodule : oss_clk_switch

`default_nettype wire

//--- oss_core.sv
// Oscillator source select, system clock switch and clock gating
//
// Chosen here: strobed register access and the placing of the registers.
`default_nettype none

module oss_core
#(
  parameter int unsigned SLOW_START = oss_pkg::SLOW_START_EDGES,
  parameter int unsigned FAST_START = oss_pkg::FAST_START_EDGES
)
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [7:0] reg_rdata_o,
  // Configuration options
  input wire logic [1:0] cfg_fast_src_i,
  input wire logic [1:0] cfg_slow_src_i,
  // Oscillator outputs
  input wire logic osc_fast_xtal_i,
  input wire logic osc_fast_rc_i,
  input wire logic osc_slow_xtal_i,
  input wire logic osc_slow_rc_i,
  // Processor halt
  input wire logic cpu_halt_i,
  // Oscillator controls
  output logic fast_xtal_en_o,
  output logic fast_rc_en_o,
  output logic slow_xtal_en_o,
  output logic slow_rc_en_o,
  output logic slow_crystal_low_power_o,
  output oss_pkg::oss_pins_s pin_mode_o,
  output logic cfg_err_o,
  // Derived clocks
  output logic sys_clk_o,
  output logic cpu_clk_o,
  output logic wdt_clk_o,
  output logic timebase_clk_o
);

  localparam int unsigned SCW = $clog2(SLOW_START + 1);
  localparam int unsigned FCW = $clog2(FAST_START + 1);
  localparam logic [SCW-1:0] SLOW_DONE = SCW'(SLOW_START);
  localparam logic [FCW-1:0] FAST_DONE = FCW'(FAST_START);

  // Two-stage synchronisers for pins and oscillators
  wire logic [oss_pkg::SYN_W-1:0] raw;
  logic [oss_pkg::SYN_W-1:0] syn1_reg;
  logic [oss_pkg::SYN_W-1:0] syn2_reg;

  assign raw = {cfg_slow_src_i, cfg_fast_src_i, osc_slow_rc_i, osc_slow_xtal_i,
                osc_fast_rc_i, osc_fast_xtal_i};

  genvar gi;
  generate
    for (gi = 0; gi < oss_pkg::SYN_W; gi++)
    begin : g_sync
      always_ff @(posedge clk_sys_i)
      begin
        if (!reset_n_i)
        begin
          syn1_reg[gi] <= 1'b0;
          syn2_reg[gi] <= 1'b0;
        end
        else
        begin
          syn1_reg[gi] <= raw[gi];
          syn2_reg[gi] <= syn1_reg[gi];
        end
      end
    end
  endgenerate

  // Configuration capture after reset release
  logic [1:0] strap_cnt_reg;
  logic strap_done_reg;
  logic fast_xtal_reg;
  logic slow_xtal_reg;
  logic cfg_err_reg;
  wire logic [1:0] cfg_fast;
  wire logic [1:0] cfg_slow;
  wire logic fast_ok;
  wire logic slow_ok;
  wire logic want_fx;
  wire logic want_sx;
  wire logic pin_clash;

  assign cfg_fast = syn2_reg[oss_pkg::SYN_CFG +: 2];
  assign cfg_slow = syn2_reg[oss_pkg::SYN_CFG + 2 +: 2];
  assign fast_ok = (cfg_fast == oss_pkg::CFG_SRC_XTAL) || (cfg_fast == oss_pkg::CFG_SRC_RC);
  assign slow_ok = (cfg_slow == oss_pkg::CFG_SRC_XTAL) || (cfg_slow == oss_pkg::CFG_SRC_RC);
  assign want_fx = cfg_fast == oss_pkg::CFG_SRC_XTAL;
  assign want_sx = cfg_slow == oss_pkg::CFG_SRC_XTAL;
  assign pin_clash = want_fx && want_sx;

  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      strap_cnt_reg <= 2'h0;
      strap_done_reg <= 1'b0;
      fast_xtal_reg <= 1'b0;
      slow_xtal_reg <= 1'b0;
      cfg_err_reg <= 1'b0;
    end
    else if (!strap_done_reg)
    begin
      strap_cnt_reg <= strap_cnt_reg + 2'h1;
      if (strap_cnt_reg == oss_pkg::STRAP_WAIT)
      begin
        strap_done_reg <= 1'b1;
        fast_xtal_reg <= want_fx;
        slow_xtal_reg <= want_sx && !pin_clash;
        cfg_err_reg <= !fast_ok || !slow_ok || pin_clash;
      end
    end
  end

  // Selected source levels and edges
  wire logic fast_lvl;
  wire logic slow_lvl;
  logic fast_prev_reg;
  logic slow_prev_reg;
  wire logic fast_rise;
  wire logic slow_rise;

  assign fast_lvl = fast_xtal_reg ? syn2_reg[oss_pkg::SYN_FX] : syn2_reg[oss_pkg::SYN_FR];
  assign slow_lvl = slow_xtal_reg ? syn2_reg[oss_pkg::SYN_SX] : syn2_reg[oss_pkg::SYN_SR];
  assign fast_rise = fast_lvl && !fast_prev_reg;
  assign slow_rise = slow_lvl && !slow_prev_reg;

  // Registers
  logic [7:0] mode_reg;
  logic lp_reg;
  logic syson_reg;
  logic [7:0] rdata_reg;
  wire logic wr_mode;
  wire logic wr_tbc;
  wire logic wr_cfg;

  assign wr_mode = reg_we_i && (reg_addr_i == oss_pkg::ADDR_MODE);
  assign wr_tbc = reg_we_i && (reg_addr_i == oss_pkg::ADDR_TBC);
  assign wr_cfg = reg_we_i && (reg_addr_i == oss_pkg::ADDR_CFG);

  // Start-up counters
  logic [SCW-1:0] slow_cnt_reg;
  logic [FCW-1:0] fast_cnt_reg;
  logic [5:0] div_reg;
  wire logic slow_rdy;
  wire logic fast_rdy;
  wire logic fast_run;

  assign slow_rdy = slow_cnt_reg == SLOW_DONE;
  assign fast_rdy = fast_cnt_reg == FAST_DONE;

  // Requested system clock
  wire logic hl_bit;
  wire logic idle_bit;
  wire logic [2:0] div_sel;
  wire oss_pkg::oss_sel_e req_sel;
  wire logic req_ok;
  wire oss_pkg::oss_sel_e cur_sel;
  wire logic sw_clk;
  wire logic [7:0] cand;

  assign hl_bit = mode_reg[oss_pkg::MODE_SPEED_BIT];
  assign idle_bit = mode_reg[oss_pkg::MODE_IDLE_BIT];
  assign div_sel = mode_reg[oss_pkg::MODE_DIV_LSB +: 3];
  assign req_sel = hl_bit ? oss_pkg::SEL_FAST :
                   (div_sel < 3'h2) ? oss_pkg::SEL_SLOW :
                   oss_pkg::oss_sel_e'(div_sel - 3'h1);
  assign req_ok = strap_done_reg && ((req_sel == oss_pkg::SEL_SLOW) ? slow_rdy : fast_rdy);
  assign cand = {fast_lvl, div_reg[0], div_reg[1], div_reg[2], div_reg[3], div_reg[4],
                 div_reg[5], slow_lvl};

  oss_clk_switch u_switch
  (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .cand_i(cand),
    .req_sel_i(req_sel),
    .req_ok_i(req_ok),
    .clk_o(sw_clk),
    .cur_sel_o(cur_sel)
  );

  // Power states
  wire logic sleep_st;
  wire logic idle0_st;
  wire logic fast_need;

  assign sleep_st = cpu_halt_i && !idle_bit;
  assign idle0_st = cpu_halt_i && idle_bit && !syson_reg;
  assign fast_need = (req_sel != oss_pkg::SEL_SLOW) || (cur_sel != oss_pkg::SEL_SLOW);
  assign fast_run = strap_done_reg && fast_need && !sleep_st && !idle0_st;

  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      fast_prev_reg <= 1'b0;
      slow_prev_reg <= 1'b0;
      slow_cnt_reg <= '0;
      fast_cnt_reg <= '0;
      div_reg <= 6'h00;
    end
    else
    begin
      fast_prev_reg <= fast_lvl;
      slow_prev_reg <= slow_lvl;
      if (slow_rise && strap_done_reg && !slow_rdy)
      begin
        slow_cnt_reg <= slow_cnt_reg + SCW'(1);
      end
      if (!fast_run)
      begin
        fast_cnt_reg <= '0;
      end
      else if (fast_rise && !fast_rdy)
      begin
        fast_cnt_reg <= fast_cnt_reg + FCW'(1);
      end
      if (fast_rise)
      begin
        div_reg <= div_reg + 6'h01;
      end
    end
  end

  // Register writes; power-on clears low-power bit
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      mode_reg <= oss_pkg::MODE_RST;
      lp_reg <= oss_pkg::TBC_LP_RST;
      syson_reg <= 1'b0;
    end
    else
    begin
      if (wr_mode)
      begin
        mode_reg <= reg_wdata_i & oss_pkg::MODE_WMASK;
      end
      if (wr_tbc)
      begin
        lp_reg <= reg_wdata_i[oss_pkg::TBC_LP_BIT];
      end
      if (wr_cfg)
      begin
        syson_reg <= reg_wdata_i[oss_pkg::CFG_SYSON_BIT];
      end
    end
  end

  // Read mux
  wire logic [7:0] mode_rd;
  wire logic [7:0] tbc_rd;
  wire logic [7:0] cfg_rd;
  wire logic [7:0] rd_mux;

  assign mode_rd = (mode_reg & oss_pkg::MODE_WMASK)
                   | (8'(fast_rdy) << oss_pkg::MODE_FRDY_BIT)
                   | (8'(slow_rdy) << oss_pkg::MODE_SRDY_BIT);
  assign tbc_rd = 8'(lp_reg) << oss_pkg::TBC_LP_BIT;
  assign cfg_rd = (8'(syson_reg) << oss_pkg::CFG_SYSON_BIT)
                  | (8'(fast_xtal_reg) << oss_pkg::CFG_FXTAL_BIT)
                  | (8'(slow_xtal_reg) << oss_pkg::CFG_SXTAL_BIT)
                  | (8'(cfg_err_reg) << oss_pkg::CFG_ERR_BIT)
                  | (8'(strap_done_reg) << oss_pkg::CFG_DONE_BIT);
  assign rd_mux = (reg_addr_i == oss_pkg::ADDR_MODE) ? mode_rd :
                  (reg_addr_i == oss_pkg::ADDR_TBC) ? tbc_rd :
                  (reg_addr_i == oss_pkg::ADDR_CFG) ? cfg_rd : 8'h00;

  // Clock gates move only while the gated clock is low
  logic sys_gate_reg;
  logic cpu_gate_reg;
  logic tb_gate_reg;
  logic sys_clk_reg;
  logic cpu_clk_reg;
  logic wdt_clk_reg;
  logic tb_clk_reg;
  oss_pkg::oss_pins_s pins_reg;
  oss_pkg::oss_pins_s pins_next;
  logic fx_en_reg;
  logic fr_en_reg;
  logic sx_en_reg;
  logic sr_en_reg;

  always_comb
  begin
    pins_next.gpio = !fast_xtal_reg && !slow_xtal_reg;
    pins_next.fast_xtal = fast_xtal_reg;
    pins_next.slow_xtal = slow_xtal_reg;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      sys_gate_reg <= 1'b0;
      cpu_gate_reg <= 1'b0;
      tb_gate_reg <= 1'b0;
      sys_clk_reg <= 1'b0;
      cpu_clk_reg <= 1'b0;
      wdt_clk_reg <= 1'b0;
      tb_clk_reg <= 1'b0;
      pins_reg <= '0;
      fx_en_reg <= 1'b0;
      fr_en_reg <= 1'b0;
      sx_en_reg <= 1'b0;
      sr_en_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end
    else
    begin
      if (!sw_clk)
      begin
        sys_gate_reg <= !sleep_st && !idle0_st;
        cpu_gate_reg <= !cpu_halt_i;
      end
      if (!slow_lvl)
      begin
        tb_gate_reg <= !sleep_st && strap_done_reg;
      end
      sys_clk_reg <= sw_clk && sys_gate_reg;
      cpu_clk_reg <= sw_clk && cpu_gate_reg;
      wdt_clk_reg <= slow_lvl && strap_done_reg;
      tb_clk_reg <= slow_lvl && tb_gate_reg;
      pins_reg <= pins_next;
      fx_en_reg <= fast_run && fast_xtal_reg;
      fr_en_reg <= fast_run && !fast_xtal_reg;
      sx_en_reg <= strap_done_reg && slow_xtal_reg;
      sr_en_reg <= strap_done_reg && !slow_xtal_reg;
      rdata_reg <= reg_re_i ? rd_mux : 8'h00;
    end
  end

  assign reg_rdata_o = rdata_reg;
  assign fast_xtal_en_o = fx_en_reg;
  assign fast_rc_en_o = fr_en_reg;
  assign slow_xtal_en_o = sx_en_reg;
  assign slow_rc_en_o = sr_en_reg;
  assign slow_crystal_low_power_o = lp_reg;
  assign pin_mode_o = pins_reg;
  assign cfg_err_o = cfg_err_reg;
  assign sys_clk_o = sys_clk_reg;
  assign cpu_clk_o = cpu_clk_reg;
  assign wdt_clk_o = wdt_clk_reg;
  assign timebase_clk_o = tb_clk_reg;

endmodule : oss_core

`default_nettype wire

//--- oss_core_properties.sv
// Port checks of the oscillator source select block
`default_nettype none

module oss_core_properties
(
  // Clock, reset and register port
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  input wire logic [7:0] reg_rdata_o,
  // Options and halt
  input wire logic [1:0] cfg_fast_src_i,
  input wire logic [1:0] cfg_slow_src_i,
  input wire logic cpu_halt_i,
  // Outputs watched
  input wire logic fast_xtal_en_o,
  input wire logic slow_xtal_en_o,
  input wire logic slow_crystal_low_power_o,
  input wire oss_pkg::oss_pins_s pin_mode_o,
  input wire logic cfg_err_o,
  input wire logic sys_clk_o,
  input wire logic cpu_clk_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] age_reg;
  logic lp_reg;
  wire logic lp_o = slow_crystal_low_power_o;
  wire logic tbc_wr = reg_we_i && reg_addr_i == oss_pkg::ADDR_TBC;
  wire logic capt = age_reg == 4'hf;
  wire logic f_x = cfg_fast_src_i == oss_pkg::CFG_SRC_XTAL;
  wire logic s_x = cfg_slow_src_i == oss_pkg::CFG_SRC_XTAL;
  wire logic f_ok = f_x || cfg_fast_src_i == oss_pkg::CFG_SRC_RC;
  wire logic s_ok = s_x || cfg_slow_src_i == oss_pkg::CFG_SRC_RC;

  // Cycles since reset, last low-power bit written
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      age_reg <= 4'h0;
      lp_reg <= 1'h0;
    end
    else
    begin
      age_reg <= capt ? age_reg : age_reg + 4'h1;
      lp_reg <= tbc_wr ? reg_wdata_i[0] : lp_reg;
    end
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence s_halt_held;
    cpu_halt_i [*8];
  endsequence
  sequence s_clk_rise;
    $rose(sys_clk_o);
  endsequence

  AST_RESET_OUT: assert property ($rose(reset_n_i) |-> !lp_o && !cfg_err_o
    && !sys_clk_o && !cpu_clk_o) else $error("outputs not clear after reset");
  AST_RDATA_IDLE: assert property (!reg_re_i |=> reg_rdata_o == 8'h00)
    else $error("read data outside read slot");
  AST_LP_WRITE: assert property (tbc_wr |=> ##[0:1] lp_o == lp_reg)
    else $error("low-power output not following write");
  AST_TBC_READ: assert property (reg_re_i && reg_addr_i == oss_pkg::ADDR_TBC
    |=> reg_rdata_o == {7'h00, lp_reg}) else $error("time-base read wrong");
  AST_XTAL_EXCL: assert property (!(fast_xtal_en_o && slow_xtal_en_o))
    else $error("both crystals enabled");
  AST_PIN_ONEHOT: assert property ($onehot0(pin_mode_o))
    else $error("shared pins given two functions");
  AST_RC_GPIO: assert property (capt && !f_x && !s_x |-> pin_mode_o.gpio)
    else $error("pins not general I/O");
  AST_SLOW_PINS: assert property (capt && !s_x |-> !pin_mode_o.slow_xtal
    && !slow_xtal_en_o) else $error("slow crystal pins held");
  AST_CFG_ERR: assert property (capt && (!f_ok || !s_ok || f_x && s_x) |-> cfg_err_o)
    else $error("bad option not flagged");
  AST_HALT_GATE: assert property (s_halt_held |-> !$rose(cpu_clk_o))
    else $error("processor clock runs in halt");
  AST_NO_RUNT: assert property (s_clk_rise |=> sys_clk_o [*4])
    else $error("runt high pulse on system clock");
endmodule : oss_core_properties

bind oss_core oss_core_properties u_props (.clk_sys_i, .reset_n_i, .reg_addr_i, .reg_wdata_i,
  .reg_we_i, .reg_re_i, .reg_rdata_o, .cfg_fast_src_i, .cfg_slow_src_i, .cpu_halt_i,
  .fast_xtal_en_o, .slow_xtal_en_o, .slow_crystal_low_power_o, .pin_mode_o, .cfg_err_o,
  .sys_clk_o, .cpu_clk_o);

`default_nettype wire

//--- oss_osc_model.sv
// Behavioural oscillators behind the clock source inputs
`default_nettype none

module oss_osc_model
#(
  parameter int unsigned FAST_XTAL_HZ = 5_000_000
)
(
  // Enables: slow rc, slow xtal, fast rc, fast xtal
  input wire logic [3:0] en_i,
  // Oscillator levels, same order
  output var logic [3:0] osc_o
);
  timeunit 1ns;
  timeprecision 100ps;

  function automatic real half_ns(input int idx);
    case (idx)
      0: return 5.0e8 / FAST_XTAL_HZ;
      1: return 5.0e8 / oss_pkg::FAST_RC_HZ;
      2: return 5.0e8 / oss_pkg::SLOW_XTAL_HZ;
      default: return 5.0e8 / oss_pkg::SLOW_RC_HZ;
    endcase
  endfunction : half_ns

  // Stands low while disabled
  for (genvar g = 0; g < 4; g++)
  begin : g_osc
    always
    begin
      osc_o[g] = 1'h0;
      wait (en_i[g] === 1'h1);
      if (g % 2 == 0) #(4.0 * half_ns(g));
      while (en_i[g] === 1'h1)
        #(half_ns(g)) osc_o[g] = ~osc_o[g];
    end
  end
endmodule : oss_osc_model

`default_nettype wire

//--- oss_core_tb.sv
// Self-checking bench of the oscillator source select block
`default_nettype none

module oss_core_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [1:0] X = oss_pkg::CFG_SRC_XTAL;
  localparam logic [1:0] R = oss_pkg::CFG_SRC_RC;
  localparam logic [1:0] CF [6] = '{X, R, R, X, 2'h0, R};
  localparam logic [1:0] CS [6] = '{R, X, R, X, R, 2'h3};
  localparam logic [7:0] MV [5] = '{8'h00, 8'h20, 8'h40, 8'h60, 8'h03};
  localparam logic [7:0] HM [4] = '{8'h01, 8'h03, 8'h03, 8'h03};
  localparam logic [3:0] HX [4] = '{4'h2, 4'h3, 4'h7, 4'hf};
  localparam int KHZ = oss_pkg::CLK_SYS_HZ / 1000;
  logic clk_sys_i, reset_n_i, reg_we_i, reg_re_i, cpu_halt_i;
  logic [3:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o;
  logic [1:0] cfg_fast_src_i, cfg_slow_src_i;
  logic fast_xtal_en_o, fast_rc_en_o, slow_xtal_en_o, slow_rc_en_o, cfg_err_o;
  logic slow_crystal_low_power_o, sys_clk_o, cpu_clk_o, wdt_clk_o, timebase_clk_o;
  oss_pkg::oss_pins_s pin_mode_o;
  wire logic osc_fast_xtal_i, osc_fast_rc_i, osc_slow_xtal_i, osc_slow_rc_i;
  int err_total = 0;
  int cmp_count = 0;

  oss_core #(.SLOW_START(4), .FAST_START(4)) DUT (.clk_sys_i, .reset_n_i, .reg_addr_i,
    .reg_wdata_i, .reg_we_i, .reg_re_i, .reg_rdata_o, .cfg_fast_src_i, .cfg_slow_src_i,
    .osc_fast_xtal_i, .osc_fast_rc_i, .osc_slow_xtal_i, .osc_slow_rc_i, .cpu_halt_i,
    .fast_xtal_en_o, .fast_rc_en_o, .slow_xtal_en_o, .slow_rc_en_o, .slow_crystal_low_power_o,
    .pin_mode_o, .cfg_err_o, .sys_clk_o, .cpu_clk_o, .wdt_clk_o, .timebase_clk_o);
  oss_osc_model u_osc (.en_i({slow_rc_en_o, slow_xtal_en_o, fast_rc_en_o, fast_xtal_en_o}),
    .osc_o({osc_slow_rc_i, osc_slow_xtal_i, osc_fast_rc_i, osc_fast_xtal_i}));

  always #5 clk_sys_i = ~clk_sys_i;

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      $display("unexpected %s: expected %0h seen %0h", what, e, g);
      err_total++;
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_we_i <= 1'h1;
    @(posedge clk_sys_i);
    reg_we_i <= 1'h0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_re_i <= 1'h1;
    @(posedge clk_sys_i);
    reg_re_i <= 1'h0;
    #1 d = reg_rdata_o;
  endtask : rd

  task automatic rst(input logic [1:0] f, input logic [1:0] s);
    @(posedge clk_sys_i);
    reset_n_i <= 1'h0;
    cfg_fast_src_i <= f;
    cfg_slow_src_i <= s;
    repeat (3) @(posedge clk_sys_i);
    reset_n_i <= 1'h1;
  endtask : rst

  // Cycles up to the next rising level of the system clock
  task automatic rise(output int n);
    logic p;
    n = 0;
    p = 1'h1;
    while (!(p === 1'h0 && sys_clk_o === 1'h1) && n < 20000)
    begin
      p = sys_clk_o;
      @(posedge clk_sys_i);
      n++;
    end
  endtask : rise

  // Polls the mode register until the slow source has its start-up count
  task automatic wait_rdy();
    logic [7:0] d;
    int n;
    d = 8'h00;
    n = 0;
    while (!d[oss_pkg::MODE_SRDY_BIT] && n < 15000)
    begin
      rd(oss_pkg::ADDR_MODE, d);
      n++;
    end
    chk("slow ready", 1'h1, d[oss_pkg::MODE_SRDY_BIT]);
  endtask : wait_rdy

  // Two settling periods, then one measured, sampling jitter allowed
  task automatic meas(input int e);
    int n;
    repeat (3) rise(n);
    chk("clock period", e, (n >= e - 2 && n <= e + 2) ? e : n);
  endtask : meas

  task automatic t_lp();
    logic [7:0] d;
    rst(R, X);
    rd(oss_pkg::ADDR_MODE, d);
    chk("mode reset", oss_pkg::MODE_RST, d);
    rd(oss_pkg::ADDR_TBC, d);
    chk("tbc reset", 8'h00, d);
    wr(4'hf, 8'hff);
    rd(4'hf, d);
    chk("unmapped", 8'h00, d);
    wait_rdy();
    wr(oss_pkg::ADDR_MODE, 8'h00);
    meas(oss_pkg::CLK_SYS_HZ / oss_pkg::SLOW_XTAL_HZ);
    wr(oss_pkg::ADDR_TBC, 8'hff);
    rd(oss_pkg::ADDR_TBC, d);
    chk("tbc lp", 8'h01, d);
    chk("lp out", 1'h1, slow_crystal_low_power_o);
    meas(oss_pkg::CLK_SYS_HZ / oss_pkg::SLOW_XTAL_HZ);
  endtask : t_lp

  task automatic t_cfg();
    logic [7:0] d;
    logic fx, sx, e;
    for (int i = 0; i < 6; i++)
    begin
      fx = CF[i] == X;
      sx = CS[i] == X && !fx;
      e = !(CF[i] inside {X, R}) || !(CS[i] inside {X, R}) || (fx && CS[i] == X);
      rst(CF[i], CS[i]);
      repeat (10) @(posedge clk_sys_i);
      rd(oss_pkg::ADDR_CFG, d);
      chk("cfg status", {3'h0, 1'h1, e, sx, fx, 1'h0}, d);
      chk("pin mode", {!fx && !sx, fx, sx}, pin_mode_o);
      chk("crystal enables", {fx, sx}, {fast_xtal_en_o, slow_xtal_en_o});
      chk("rc enables", {!fx, !sx}, {fast_rc_en_o, slow_rc_en_o});
      chk("cfg error", e, cfg_err_o);
    end
  endtask : t_cfg

  task automatic t_clk();
    logic [7:0] d;
    int e;
    rst(R, R);
    wait_rdy();
    for (int i = 0; i < 5; i++)
    begin
      wr(oss_pkg::ADDR_MODE, MV[i]);
      if (MV[i][0])
        e = KHZ / (oss_pkg::FAST_RC_HZ / 1000);
      else if (MV[i][7:5] < 3'h2)
        e = KHZ / (oss_pkg::SLOW_RC_HZ / 1000);
      else
        e = KHZ * (256 >> MV[i][7:5]) / (oss_pkg::FAST_RC_HZ / 1000);
      meas(e);
    end
    rd(oss_pkg::ADDR_MODE, d);
    chk("ready bits", 2'h3, d[3:2]);
  endtask : t_clk

  // Sleep, idle off, idle on, running: rising levels seen per clock
  task automatic t_halt();
    logic [3:0] v, p, seen;
    for (int i = 0; i < 4; i++)
    begin
      wr(oss_pkg::ADDR_MODE, HM[i]);
      wr(oss_pkg::ADDR_CFG, {7'h00, i == 2});
      cpu_halt_i <= i < 3;
      repeat (50) @(posedge clk_sys_i);
      seen = 4'h0;
      p = 4'hf;
      repeat (3500)
      begin
        @(posedge clk_sys_i);
        v = {cpu_clk_o, sys_clk_o, wdt_clk_o, timebase_clk_o};
        seen = seen | (v & ~p);
        p = v;
      end
      chk("clock activity", HX[i], seen);
    end
  endtask : t_halt

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim

  initial
  begin
    clk_sys_i = 1'h0;
    reset_n_i = 1'h0;
    reg_addr_i = 4'h0;
    reg_wdata_i = 8'h00;
    reg_we_i = 1'h0;
    reg_re_i = 1'h0;
    cfg_fast_src_i = R;
    cfg_slow_src_i = R;
    cpu_halt_i = 1'h0;
    t_lp();
    t_cfg();
    t_clk();
    t_halt();
    end_sim();
  end

  initial
  begin
    #1_000_000;
    err_total++;
    end_sim();
  end
endmodule : oss_core_tb

`default_nettype wire
